// ==== umpc_consts.svh ====
`ifndef UMPC_CONSTS_SVH
`define UMPC_CONSTS_SVH
// ***********************************************
// register offsets inside one channel window
// ***********************************************
`define UMPC_OFF_MCR   5'h00
`define UMPC_OFF_DMA   5'h04
`define UMPC_OFF_STAT  5'h08
`define UMPC_OFF_MASK  5'h0c
`define UMPC_OFF_PINS  5'h10
// address bit that selects channel b
`define UMPC_CHAN_BIT  5
// ***********************************************
// field positions
// ***********************************************
`define UMPC_MCR_RTS   1
`define UMPC_MCR_OUT2  3
`define UMPC_MCR_LOOP  4
`define UMPC_DMA_MODE  8
`define UMPC_EV_RING   0
`define UMPC_EV_RXAV   1
// ***********************************************
// reset values
// ***********************************************
`define UMPC_MCR_RST   3'h0
`define UMPC_TRIG_RST  8'h01
`define UMPC_MASK_RST  2'h0
`define UMPC_STAT_RST  2'h0
`endif

// ==== umpc_pkg.sv ====
// ***********************************************
// shared types of the modem pin control block
// ***********************************************
package umpc_pkg;
    // modem control bits kept per channel
    typedef struct packed {
        logic loop;  // local loopback
        logic out2;  // irq pin active, aux low
        logic rts;   // request to send
    } umpc_mcr_t;
    // receive dma configuration
    typedef struct packed {
        logic       mode; // 0 single, 1 block
        logic [7:0] trig; // receive trigger level
    } umpc_dma_t;
    // pins and core signals entering a channel
    typedef struct packed {
        logic       ring_n;    // ring indicator, active low
        logic       serial_in; // external receive line
        logic       tx_serial; // transmit data from core
        logic [7:0] rx_level;  // receive fifo fill level
    } umpc_pin_in_t;
    // pins and core signals leaving a channel
    typedef struct packed {
        logic irq;       // channel interrupt value
        logic irq_oe;    // interrupt pin driven
        logic aux_n;     // auxiliary output
        logic rts_n;     // request to send pin
        logic rx_core;   // serial data to receiver
        logic rx_avail_n; // receive ready pin
    } umpc_pin_out_t;
    // receive ready state
    typedef enum logic [1:0] {
        UMPC_ST_IDLE = 2'b01,
        UMPC_ST_HOLD = 2'b10
    } umpc_rx_st_t;
endpackage

// ==== umpc_chan.sv ====
`timescale 1ns/1ns
`include "umpc_consts.svh"
// ***********************************************
// pin logic of one channel
// ***********************************************
module umpc_chan
    import umpc_pkg::*;
(
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          soft_rst,  // master reset, decoded
    input  wire umpc_mcr_t     modem_ctrl_reg,       // modem control bits
    input  wire umpc_dma_t     dma,       // dma configuration
    input  wire umpc_pin_in_t  pin_in,    // channel inputs
    input  wire logic          irq_pend,  // unmasked status pending
    output umpc_pin_out_t      pin_out,   // channel outputs
    output logic [1:0]         ev         // event pulses
);
    logic        ring_q;    // last ring level
    logic        avail_q;   // last receive ready
    umpc_rx_st_t st_q;      // receive ready state
    umpc_rx_st_t st_d;
    logic        any_char;  // at least one character
    logic        at_trig;   // trigger level reached
    logic        avail;     // receive ready, active high

    // ***********************************************
    // receive ready decode
    // ***********************************************
    assign any_char = pin_in.rx_level != 8'h00;
    assign at_trig  = any_char && (pin_in.rx_level >= dma.trig);
    // mode 0 any char, mode 1 trigger then hold till empty
    // block mode asserts on the trigger edge itself, then holds while not empty
    assign avail = dma.mode ? (at_trig || (any_char && (st_q == UMPC_ST_HOLD)))
                            : any_char;

    // block mode state
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            UMPC_ST_IDLE: if (at_trig) st_d = UMPC_ST_HOLD;
            UMPC_ST_HOLD: if (!any_char) st_d = UMPC_ST_IDLE;
            default:      st_d = UMPC_ST_IDLE;
        endcase
    end

    // state and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q    <= UMPC_ST_IDLE;
            ring_q  <= 1'b1;
            avail_q <= 1'b0;
        end else if (soft_rst) begin
            st_q    <= UMPC_ST_IDLE;
            ring_q  <= 1'b1;
            avail_q <= 1'b0;
        end else begin
            st_q    <= st_d;
            ring_q  <= pin_in.ring_n;
            avail_q <= avail;
        end
    end

    // ***********************************************
    // events and pins
    // ***********************************************
    // ring line going back to one
    assign ev[`UMPC_EV_RING] = pin_in.ring_n & ~ring_q;
    // receive ready newly asserted
    assign ev[`UMPC_EV_RXAV] = avail & ~avail_q;

    assign pin_out.irq        = irq_pend;
    assign pin_out.irq_oe     = modem_ctrl_reg.out2;
    assign pin_out.aux_n      = ~modem_ctrl_reg.out2;
    assign pin_out.rts_n      = ~modem_ctrl_reg.rts;
    // loopback ignores the external line
    assign pin_out.rx_core    = modem_ctrl_reg.loop ? pin_in.tx_serial : pin_in.serial_in;
    assign pin_out.rx_avail_n = ~avail;
endmodule // umpc_chan

// ==== umpc_top.sv ====
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "umpc_consts.svh"
// Behaviour
// - bit three set: irq driven, aux low
// - bit three clear: irq released, aux high
// - bus mode high: master reset active high
// - bus mode low: master reset active low
// - ring line rising raises enabled interrupt
// - bit one set drives request low
// - request to send high after reset
// - loopback feeds transmit data to receiver
// - receive ready low when characters wait, in mode 1 once trigger reached
// - receive ready high when empty, or below trigger in mode 1 before hold
// - receive ready serves both dma modes
module umpc_top
    import umpc_pkg::*;
#(
    parameter int ADDR_W = 8  // apb address width
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    // ***********************************************
    // apb slave
    // ***********************************************
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    // ***********************************************
    // device pins
    // ***********************************************
    input  wire logic              bus_mode_sel,
    input  wire logic              master_rst,
    input  wire logic              chan_a_ring_in_n,
    input  wire logic              chan_b_ring_in_n,
    input  wire logic              chan_a_serial_in,
    input  wire logic              chan_b_serial_in,
    input  wire logic              chan_a_tx_serial,
    input  wire logic              chan_b_tx_serial,
    input  wire logic [7:0]        chan_a_rx_level,
    input  wire logic [7:0]        chan_b_rx_level,
    output logic                   chan_a_irq_out,
    output logic                   chan_a_irq_out_oe,
    output logic                   chan_b_irq_out,
    output logic                   chan_b_irq_out_oe,
    output logic                   chan_a_aux_output_n,
    output logic                   chan_b_aux_output_n,
    output logic                   chan_a_send_request_n,
    output logic                   chan_b_send_request_n,
    output logic                   chan_a_rx_core,
    output logic                   chan_b_rx_core,
    output logic                   chan_a_rx_avail_n,
    output logic                   chan_b_rx_avail_n,
    output logic                   irq
);
    // ***********************************************
    // declarations
    // ***********************************************
    localparam int NCH = 2;          // channel count

    logic          soft_rst;         // decoded master reset
    logic          ch_sel;           // addressed channel
    logic [4:0]    off;              // offset in window
    logic          hi_zero;          // upper address clear
    logic          off_ok;           // offset is mapped
    logic          hit;              // mapped access
    logic          setup_rd;         // read setup phase
    logic          acc;              // access phase edge
    logic          wr;               // write takes effect
    logic          rd;               // read completes
    logic [31:0]   rd_val;           // selected read data
    logic [31:0]   prdata_q;         // registered read data

    umpc_mcr_t     mcr_q  [NCH];     // modem control
    umpc_dma_t     dma_q  [NCH];     // dma configuration
    logic [1:0]    stat_q [NCH];     // sticky events
    logic [1:0]    mask_q [NCH];     // event mask
    umpc_pin_in_t  pin_in [NCH];     // channel inputs
    umpc_pin_out_t pin_out[NCH];     // channel outputs
    logic [1:0]    ev     [NCH];     // event pulses
    logic          pend   [NCH];     // channel interrupt
    logic [31:0]   ch_rd  [NCH];     // per channel read

    // ***********************************************
    // master reset polarity
    // ***********************************************
    // pin polarity follows the bus mode select
    assign soft_rst = bus_mode_sel ? master_rst : ~master_rst;

    // ***********************************************
    // apb decode
    // ***********************************************
    assign ch_sel  = paddr[`UMPC_CHAN_BIT];
    assign off     = paddr[4:0];
    assign hi_zero = (paddr >> (`UMPC_CHAN_BIT + 1)) == '0;
    assign off_ok  = (off == `UMPC_OFF_MCR)  ||
                     (off == `UMPC_OFF_DMA)  ||
                     (off == `UMPC_OFF_STAT) ||
                     (off == `UMPC_OFF_MASK) ||
                     (off == `UMPC_OFF_PINS);
    assign hit      = hi_zero && off_ok;
    assign setup_rd = psel && !penable && !pwrite;
    assign acc      = psel && penable;
    assign wr       = acc && pwrite && hit;
    assign rd       = acc && !pwrite && hit;

    // zero wait states, error on unmapped address
    assign pready  = 1'b1;
    assign pslverr = acc && !hit;
    assign prdata  = prdata_q;

    // ***********************************************
    // channel input packing
    // ***********************************************
    assign pin_in[0] = '{ring_n:    chan_a_ring_in_n,
                         serial_in: chan_a_serial_in,
                         tx_serial: chan_a_tx_serial,
                         rx_level:  chan_a_rx_level};
    assign pin_in[1] = '{ring_n:    chan_b_ring_in_n,
                         serial_in: chan_b_serial_in,
                         tx_serial: chan_b_tx_serial,
                         rx_level:  chan_b_rx_level};

    // ***********************************************
    // per channel registers and pin logic
    // ***********************************************
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic       sel_c;   // this channel addressed
        logic       wr_mcr;  // write modem control
        logic       wr_dma;  // write dma config
        logic       wr_mask; // write mask
        logic       rd_stat; // status read, clears
        logic [1:0] stat_d;  // next status

        assign sel_c   = (ch_sel == 1'(c));
        assign wr_mcr  = wr && sel_c && (off == `UMPC_OFF_MCR);
        assign wr_dma  = wr && sel_c && (off == `UMPC_OFF_DMA);
        assign wr_mask = wr && sel_c && (off == `UMPC_OFF_MASK);
        assign rd_stat = rd && sel_c && (off == `UMPC_OFF_STAT);
        // new events win over a clearing read
        assign stat_d  = (rd_stat ? 2'h0 : stat_q[c]) | ev[c];

        // modem control and dma config
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                mcr_q[c] <= `UMPC_MCR_RST;
                dma_q[c] <= '{mode: 1'b0, trig: `UMPC_TRIG_RST};
            end else if (soft_rst) begin
                mcr_q[c] <= `UMPC_MCR_RST;
                dma_q[c] <= '{mode: 1'b0, trig: `UMPC_TRIG_RST};
            end else begin
                if (wr_mcr) begin
                    mcr_q[c].rts  <= pwdata[`UMPC_MCR_RTS];
                    mcr_q[c].out2 <= pwdata[`UMPC_MCR_OUT2];
                    mcr_q[c].loop <= pwdata[`UMPC_MCR_LOOP];
                end
                if (wr_dma) begin
                    dma_q[c].mode <= pwdata[`UMPC_DMA_MODE];
                    dma_q[c].trig <= pwdata[7:0];
                end
            end
        end

        // sticky status and mask
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                stat_q[c] <= `UMPC_STAT_RST;
                mask_q[c] <= `UMPC_MASK_RST;
            end else if (soft_rst) begin
                stat_q[c] <= `UMPC_STAT_RST;
                mask_q[c] <= `UMPC_MASK_RST;
            end else begin
                stat_q[c] <= stat_d;
                if (wr_mask) begin
                    mask_q[c] <= pwdata[1:0];
                end
            end
        end

        // ring event reaches pin only when enabled
        assign pend[c] = |(stat_q[c] & mask_q[c]);

        // per channel read data
        assign ch_rd[c] =
            (off == `UMPC_OFF_MCR)  ? {27'h0, mcr_q[c].loop, mcr_q[c].out2, 1'b0,
                                       mcr_q[c].rts, 1'b0} :
            (off == `UMPC_OFF_DMA)  ? 32'(dma_q[c]) :
            (off == `UMPC_OFF_STAT) ? 32'(stat_q[c]) :
            (off == `UMPC_OFF_MASK) ? 32'(mask_q[c]) :
            (off == `UMPC_OFF_PINS) ? 32'({bus_mode_sel,
                                          pin_out[c].rx_avail_n,
                                          pin_out[c].rts_n,
                                          pin_in[c].serial_in,
                                          pin_in[c].ring_n}) :
            32'h0000_0000;

        umpc_chan u_chan (
            .pclk     (pclk),
            .presetn  (presetn),
            .soft_rst (soft_rst),
            .modem_ctrl_reg      (mcr_q[c]),
            .dma      (dma_q[c]),
            .pin_in   (pin_in[c]),
            .irq_pend (pend[c]),
            .pin_out  (pin_out[c]),
            .ev       (ev[c])
        );
    end

    // ***********************************************
    // read data
    // ***********************************************
    // unmapped reads return zero
    assign rd_val = hit ? ch_rd[ch_sel] : 32'h0000_0000;

    // captured in setup so it is a flop in access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_rd) begin
            prdata_q <= rd_val;
        end
    end

    // ***********************************************
    // output unpacking
    // ***********************************************
    assign chan_a_irq_out        = pin_out[0].irq;
    assign chan_a_irq_out_oe     = pin_out[0].irq_oe;
    assign chan_b_irq_out        = pin_out[1].irq;
    assign chan_b_irq_out_oe     = pin_out[1].irq_oe;
    assign chan_a_aux_output_n   = pin_out[0].aux_n;
    assign chan_b_aux_output_n   = pin_out[1].aux_n;
    assign chan_a_send_request_n = pin_out[0].rts_n;
    assign chan_b_send_request_n = pin_out[1].rts_n;
    assign chan_a_rx_core        = pin_out[0].rx_core;
    assign chan_b_rx_core        = pin_out[1].rx_core;
    assign chan_a_rx_avail_n     = pin_out[0].rx_avail_n;
    assign chan_b_rx_avail_n     = pin_out[1].rx_avail_n;

    // level interrupt, any channel unmasked
    assign irq = pend[0] | pend[1];
endmodule // umpc_top

// ==== umpc_modem.sv ====
`timescale 1ns/1ns
// ***********************************************
// far side: modem ring lines and serial source
// ***********************************************
module umpc_modem
    import umpc_pkg::*;
(
    input  wire logic [1:0] ring_req,  // ring held per channel
    input  wire logic       pclk,
    input  wire logic [1:0] send_req,  // channel sends a bit
    input  wire logic       send_bit,  // value being sent
    output logic      [1:0] ring_n,    // ring indicator, active low
    output logic      [1:0] line       // serial data lines
);
    // lines rest high from time zero, reset included
    initial begin
        ring_n = 2'b11;
        line   = 2'b11;
    end
    // pins move just after the edge
    always @(posedge pclk) begin
        ring_n <= ~ring_req;
        line   <= ~send_req | {2{send_bit}};
    end
endmodule // umpc_modem

// ==== umpc_chk.sv ====
`timescale 1ns/1ns
// ***********************************************
// pin behaviour checker
// ***********************************************
module umpc_chk
    import umpc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       pwdata,
    input wire logic              pslverr,
    input wire logic              bus_mode_sel,
    input wire logic              master_rst,
    input wire logic              chan_a_serial_in,
    input wire logic              chan_a_tx_serial,
    input wire logic [7:0]        chan_a_rx_level,
    input wire logic              chan_a_irq_out,
    input wire logic              chan_b_irq_out,
    input wire logic              chan_a_irq_out_oe,
    input wire logic              chan_a_aux_output_n,
    input wire logic              chan_a_send_request_n,
    input wire logic              chan_b_send_request_n,
    input wire logic              chan_a_rx_core,
    input wire logic              chan_a_rx_avail_n,
    input wire logic              irq
);
    // master reset as decoded by bus mode
    wire mrst_on = bus_mode_sel ? master_rst : !master_rst;
    // modem control write of channel a
    wire wr_a = psel && penable && pwrite && paddr == '0 && !mrst_on;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_aux_oe_pair: assert property (chan_a_aux_output_n == !chan_a_irq_out_oe)
        else $error("aux output and irq enable disagree");
    a_rts_after_rst: assert property ($rose(presetn) |-> chan_a_send_request_n && chan_b_send_request_n)
        else $error("request to send low after reset");
    a_rts_set: assert property (wr_a && pwdata[1] |=> !chan_a_send_request_n)
        else $error("request to send not driven low");
    a_rts_clear: assert property (wr_a && !pwdata[1] |=> chan_a_send_request_n)
        else $error("request to send not released");
    a_oe_set: assert property (wr_a && pwdata[3] |=> chan_a_irq_out_oe && !chan_a_aux_output_n)
        else $error("irq pin not enabled");
    a_loop_route: assert property (chan_a_rx_core != chan_a_serial_in |-> chan_a_rx_core == chan_a_tx_serial)
        else $error("receiver input from neither source");
    a_empty_idle: assert property (chan_a_rx_level == 8'h00 |-> chan_a_rx_avail_n)
        else $error("receive ready with empty fifo");
    a_mrst_high: assert property (bus_mode_sel && master_rst |=> chan_a_send_request_n ##1 chan_a_send_request_n || !master_rst)
        else $error("active high master reset ignored");
    a_mrst_low: assert property (!bus_mode_sel && !master_rst |=> chan_a_send_request_n)
        else $error("active low master reset ignored");
    a_unmapped_err: assert property (psel && penable && paddr[ADDR_W-1:6] != '0 |-> pslverr)
        else $error("unmapped access without error");
    a_irq_or: assert property (irq == (chan_a_irq_out || chan_b_irq_out))
        else $error("irq differs from channel pending");
endmodule // umpc_chk
bind umpc_top umpc_chk #(.ADDR_W(ADDR_W)) umpc_chk_inst (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .pslverr(pslverr), .bus_mode_sel(bus_mode_sel), .master_rst(master_rst),
    .chan_a_serial_in(chan_a_serial_in), .chan_a_tx_serial(chan_a_tx_serial),
    .chan_a_rx_level(chan_a_rx_level), .chan_a_irq_out(chan_a_irq_out),
    .chan_b_irq_out(chan_b_irq_out), .chan_a_irq_out_oe(chan_a_irq_out_oe),
    .chan_a_aux_output_n(chan_a_aux_output_n), .chan_a_send_request_n(chan_a_send_request_n),
    .chan_b_send_request_n(chan_b_send_request_n), .chan_a_rx_core(chan_a_rx_core),
    .chan_a_rx_avail_n(chan_a_rx_avail_n), .irq(irq));

// ==== uart_modem_pin_control_test.sv ====
`timescale 1ns/1ns
// ***********************************************
// bench for the modem pin control block
// ***********************************************
module uart_modem_pin_control_test;
    import umpc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_err;
    logic        bus_mode_sel, master_rst, tx_a, send_bit, irq, irq_a, oe_a;
    logic        aux_a, aux_b, rts_a, rts_b, core_a, avail_a, avail_b;
    logic [1:0]  ring_req, send_req, ring_n, line;
    logic [7:0]  paddr, rx_lv_a, rx_lv_b;
    logic [31:0] pwdata, prdata, rd_val;
    logic [7:0]  lv [6] = '{8'h01, 8'h00, 8'h02, 8'h04, 8'h02, 8'h00}; // fill levels
    logic [5:0]  ex = 6'b100110;                                       // ready pin per step
    int          cmp_count, n_mismatch;
    umpc_top umpc_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_mode_sel(bus_mode_sel), .master_rst(master_rst),
        .chan_a_ring_in_n(ring_n[0]), .chan_b_ring_in_n(ring_n[1]), .chan_a_serial_in(line[0]),
        .chan_b_serial_in(line[1]), .chan_a_tx_serial(tx_a), .chan_b_tx_serial(1'b1),
        .chan_a_rx_level(rx_lv_a), .chan_b_rx_level(rx_lv_b), .chan_a_irq_out(irq_a),
        .chan_a_irq_out_oe(oe_a), .chan_b_irq_out(), .chan_b_irq_out_oe(),
        .chan_a_aux_output_n(aux_a), .chan_b_aux_output_n(aux_b), .chan_a_rx_core(core_a),
        .chan_a_send_request_n(rts_a), .chan_b_send_request_n(rts_b), .chan_b_rx_core(),
        .chan_a_rx_avail_n(avail_a), .chan_b_rx_avail_n(avail_b), .irq(irq));
    umpc_modem umpc_modem_inst (.pclk(pclk), .ring_req(ring_req), .send_req(send_req),
        .send_bit(send_bit), .ring_n(ring_n), .line(line));
    // ***********************************************
    // tasks
    // ***********************************************
    // one apb transfer, held until pready is seen
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_val = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // compare and count
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // read and compare
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd_val);
    endtask
    // verdict and end of run
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ***********************************************
    // clock and watchdog
    // ***********************************************
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // cut a hang short
    initial begin
        repeat (5000) @(posedge pclk);
        n_mismatch++;
        results();
    end
    // ***********************************************
    // test sequence
    // ***********************************************
    initial begin
        {psel, penable, pwrite, master_rst, ring_req, send_req, send_bit} = '0;
        {paddr, pwdata, rx_lv_a, rx_lv_b} = '0;
        {tx_a, bus_mode_sel} = 2'b11;
        presetn = 1'b0;
        cmp_count = 0;
        n_mismatch = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("rts_a", 1, rts_a);
        chk("rts_b", 1, rts_b);
        chk("aux_a", 1, aux_a);
        chk("oe_a", 0, oe_a);
        rd(8'h04, 32'h1, "dma_cfg");
        rd(8'h40, 32'h0, "unmapped");
        chk("slverr", 1, rd_err);
        xfer(1'b1, 8'h00, 32'h0a);
        @(negedge pclk);
        chk("rts_a", 0, rts_a);
        chk("aux_a", 0, aux_a);
        chk("oe_a", 1, oe_a);
        chk("rts_b", 1, rts_b);
        chk("aux_b", 1, aux_b);
        @(posedge pclk);
        send_req <= 2'b01;
        for (int i = 0; i < 2; i++) begin
            xfer(1'b1, 8'h00, i ? 32'h1a : 32'h0a);
            @(negedge pclk);
            chk("rx_core", i, core_a);
        end
        xfer(1'b1, 8'h0c, 32'h1);
        send_req <= 2'b00;
        ring_req <= 2'b11;
        repeat (3) @(posedge pclk);
        ring_req <= 2'b00;
        repeat (3) @(negedge pclk);
        chk("irq", 1, irq);
        chk("irq_a", 1, irq_a);
        rd(8'h28, 32'h1, "stat_b");
        rd(8'h08, 32'h1, "stat_a");
        @(negedge pclk);
        chk("irq", 0, irq);
        for (int i = 0; i < 6; i++) begin
            if (i == 2) xfer(1'b1, 8'h04, 32'h104);
            @(posedge pclk);
            rx_lv_a <= lv[i];
            @(negedge pclk);
            chk("avail_a", ex[i], avail_a);
        end
        @(posedge pclk);
        rx_lv_b <= 8'h03;
        @(negedge pclk);
        chk("avail_b", 0, avail_b);
        xfer(1'b1, 8'h00, 32'h0a);
        master_rst <= 1'b1;
        @(posedge pclk);
        master_rst <= 1'b0;
        @(negedge pclk);
        chk("rts_a", 1, rts_a);
        rd(8'h04, 32'h1, "dma_cfg");
        xfer(1'b1, 8'h00, 32'h0a);
        bus_mode_sel <= 1'b0;
        master_rst <= 1'b1;
        repeat (2) @(negedge pclk);
        chk("rts_a", 0, rts_a);
        @(posedge pclk);
        master_rst <= 1'b0;
        @(posedge pclk);
        master_rst <= 1'b1;
        @(negedge pclk);
        chk("rts_a", 1, rts_a);
        results();
    end
endmodule // uart_modem_pin_control_test
